//--- core/ppc_pkg.sv
// package of constants and types for the parallel port chip-select and buffer block
package ppc_pkg;
    // register byte addresses on the avalon bus
    localparam logic [4:0] ADDR_CS1_CFG  = 5'h00;
    localparam logic [4:0] ADDR_CS1_BASE = 5'h04;
    localparam logic [4:0] ADDR_CS1_TIM  = 5'h08;
    localparam logic [4:0] ADDR_CS2_CFG  = 5'h0C;
    localparam logic [4:0] ADDR_CS2_BASE = 5'h10;
    localparam logic [4:0] ADDR_CS2_TIM  = 5'h14;
    localparam logic [4:0] ADDR_STATUS   = 5'h18;
    localparam logic [4:0] ADDR_CONTROL  = 5'h1C;
    // config register field positions
    localparam int CFG_OFF_BIT   = 15;
    localparam int CFG_CSPOL_BIT = 14;
    localparam int CFG_PIN_BIT   = 13;
    localparam int CFG_BEP_BIT   = 12;
    localparam int CFG_WRP_BIT   = 10;
    localparam int CFG_RDP_BIT   = 9;
    localparam int CFG_SM_BIT    = 8;
    localparam int CFG_HANDSHAKE_POLARITY_BIT  = 7;
    localparam int CFG_BUS_WIDTH_SEL_LO   = 5;
    localparam logic [15:0] CFG_WMASK  = 16'hF7E0;
    localparam logic [15:0] BASE_WMASK = 16'hFF80;
    localparam logic [15:0] TIM_WMASK  = 16'hF8FF;
    // timing register field positions
    localparam int TIM_HANDSHAKE_MODE_LO  = 14;
    localparam int TIM_AMW_LO   = 11;
    localparam int TIM_SETUP_LO = 6;
    localparam int TIM_STRB_LO  = 2;
    localparam int TIM_HOLD_LO  = 0;
    // reset values
    localparam logic [15:0] CS1_BASE_RST = 16'h0080;
    localparam logic [15:0] CS2_BASE_RST = 16'h0880;
    localparam logic [15:0] STATUS_RST   = 16'h008F;
    // status field positions
    localparam int ST_IBF  = 15;
    localparam int ST_INBUF_OVERFLOW = 14;
    localparam int ST_OBE  = 7;
    localparam int ST_OUTBUF_UNDERFLOW = 6;
    // control register fields
    localparam int CTL_MODE_LO = 0;
    localparam int CTL_IRQ_LO  = 2;
    localparam int CTL_GO_BIT  = 4;
    localparam int CTL_DIR_BIT = 5;
    localparam int CTL_CS_BIT  = 6;
    localparam int CTL_BUSY    = 8;
    localparam int CTL_TMO     = 9;
    // mode and handshake codes
    localparam logic [1:0] MODE_MASTER = 2'h3;
    localparam logic [1:0] MODE_BUF    = 2'h1;
    localparam logic [1:0] ACK_WAIT    = 2'h2;
    localparam logic [1:0] ACK_TMO     = 2'h1;
    localparam logic [1:0] IRQ_LAST    = 2'h3;
    localparam logic [1:0] WIDTH_16    = 2'h2;
    localparam logic [1:0] WIDTH_4     = 2'h1;
    // timing constants; Q_ONE to Q_THREE count quarter-cycle phases, TMO_DEFAULT_TCY counts whole Tcy
    localparam int TCY_NS       = 20;
    localparam int QPH_PER_TCY  = 4;
    localparam logic [11:0] TMO_DEFAULT_TCY = 12'h0FF;
    localparam logic [1:0]  Q_ONE  = 2'h1;
    localparam logic [1:0]  Q_TWO  = 2'h2;
    localparam logic [1:0]  Q_THREE = 2'h3;
    localparam logic [3:0]  AMW_BASE = 4'h3;
    // external pin bundle
    typedef struct packed {
        logic [1:0] select;
        logic       read_strobe;
        logic       write_strobe;
        logic       lane0_en;
        logic       lane1_en;
        logic       data_oe;
    } ppc_pins_t;
    // master phases, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STRB  = 4'b0100,
        ST_HOLD  = 4'b1000
    } ppc_state_t;
endpackage

//--- core/ppc_port.sv
// parallel port chip-select configuration, master timing and slave status
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// ================================================================
module ppc_port
    import ppc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              ext_handshake_in,
    input  wire logic              host_wr,
    input  wire logic              host_rd,
    input  wire logic [1:0]        host_idx,
    output ppc_pkg::ppc_pins_t     pins,
    output logic [1:0]             bus_width_sel,
    output logic                   region_extend,
    output logic [3:0]             alt_master_wait,
    output logic                   buf_irq
);
    import ppc_pkg::*;
    logic [15:0] cfg_ff [2];
    logic [15:0] base_ff [2];
    logic [15:0] tim_ff [2];
    logic [7:0]  ctl_ff;
    logic        ack_done_ff;
    logic        region_ext_ff;
    logic        tmo_ff;
    logic [31:0] rdata_ff;
    ppc_state_t  state_ff;
    logic [1:0]  qph_ff;
    logic [5:0]  cnt_ff;
    logic [11:0] tmo_cnt_ff;
    ppc_pins_t   pins_ff;
    logic        irq_ff;
    logic        wait_ff;
    logic [15:0] status;
    logic        last_event;
    logic        wr_acc;
    logic        rd_acc;
    logic [15:0] wdata;
    logic        cs;
    logic [15:0] cfg;
    logic [15:0] tim;
    logic        ack_seen;
    logic        q_en;
    logic        master;
    // ================================================================
    // avalon slave: one wait cycle on every access, then answer
    assign wr_acc = avs_write && wait_ff == 1'b0 && avs_waitrequest;
    assign rd_acc = avs_read && wait_ff == 1'b0 && avs_waitrequest;
    assign wdata  = avs_writedata[15:0];
    assign cs     = ctl_ff[CTL_CS_BIT];
    assign cfg    = cfg_ff[cs];
    assign tim    = tim_ff[cs];
    assign master = ctl_ff[1:0] == MODE_MASTER;
    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            wait_ff <= 1'b0;
        else
            wait_ff <= (avs_read || avs_write) && !wait_ff;
    end
    assign avs_waitrequest = !wait_ff;
    // configuration registers; byte enables on the low two lanes
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cfg_ff[0]  <= 16'h0000;
            cfg_ff[1]  <= 16'h0000;
            tim_ff[0]  <= 16'h0000;
            tim_ff[1]  <= 16'h0000;
            base_ff[0] <= CS1_BASE_RST;
            base_ff[1] <= CS2_BASE_RST;
            ctl_ff     <= 8'h00;
        end
        else
        begin
            if (wr_acc && avs_byteenable[1:0] == 2'h3)
            begin
                case (avs_address)
                    ADDR_CS1_CFG:  cfg_ff[0]  <= wdata & CFG_WMASK;
                    ADDR_CS2_CFG:  cfg_ff[1]  <= wdata & CFG_WMASK;
                    ADDR_CS1_BASE: base_ff[0] <= wdata & BASE_WMASK;
                    ADDR_CS2_BASE: base_ff[1] <= wdata & BASE_WMASK;
                    ADDR_CS1_TIM:  tim_ff[0]  <= wdata & TIM_WMASK;
                    ADDR_CS2_TIM:  tim_ff[1]  <= wdata & TIM_WMASK;
                    ADDR_CONTROL:  ctl_ff     <= wdata[7:0];
                    default:       ctl_ff     <= ctl_ff;
                endcase
            end
            else if (state_ff != ST_IDLE)
                ctl_ff[CTL_GO_BIT] <= 1'b0;                      // go self-clears
        end
    end
    // whole-word zero write to second base extends the first region
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            region_ext_ff <= 1'b0;
        else if (wr_acc && avs_address == ADDR_CS2_BASE)
            region_ext_ff <= avs_byteenable[1:0] == 2'h3 && wdata == 16'h0000;
    end
    // read mux, unmapped addresses read zero
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rdata_ff <= 32'h0000_0000;
        else if (rd_acc)
        begin
            case (avs_address)
                ADDR_CS1_CFG:  rdata_ff <= {16'h0000, cfg_ff[0]};
                ADDR_CS2_CFG:  rdata_ff <= {16'h0000, cfg_ff[1]};
                ADDR_CS1_BASE: rdata_ff <= {16'h0000, base_ff[0]};
                ADDR_CS2_BASE: rdata_ff <= {16'h0000, base_ff[1]};
                ADDR_CS1_TIM:  rdata_ff <= {16'h0000, tim_ff[0]};
                ADDR_CS2_TIM:  rdata_ff <= {16'h0000, tim_ff[1]};
                ADDR_STATUS:   rdata_ff <= {16'h0000, status};
                ADDR_CONTROL:  rdata_ff <= {22'h0, tmo_ff, state_ff != ST_IDLE, ctl_ff};
                default:       rdata_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_ff;
    // ================================================================
    // quarter-cycle phase counter; the enable q_en is held high on every clock
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            qph_ff <= 2'h0;
        else
            qph_ff <= qph_ff + 2'h1;
    end
    assign q_en = 1'b1;   // each clock is one quarter phase of Tcy
    // handshake polarity: xnor makes active level programmable
    assign ack_seen = ext_handshake_in ~^ cfg[CFG_HANDSHAKE_POLARITY_BIT];
    // master phase machine, counts in quarter phases
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 6'h00;
            tmo_cnt_ff <= 12'h000;
            tmo_ff     <= 1'b0;
        end
        else if (q_en)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (master && ctl_ff[CTL_GO_BIT] && !cfg[CFG_OFF_BIT])
                    begin
                        state_ff <= ST_SETUP;
                        cnt_ff   <= {2'h0, tim[TIM_SETUP_LO +: 2], 2'h0}
                                    + {4'h0, Q_ONE};
                        tmo_ff   <= 1'b0;
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_ff <= 6'h01)
                    begin
                        state_ff   <= ST_STRB;
                        cnt_ff     <= {tim[TIM_STRB_LO +: 4], 2'h0}
                                      + (ctl_ff[CTL_DIR_BIT] ? {4'h0, Q_TWO}
                                                             : {4'h0, Q_THREE});
                        tmo_cnt_ff <= (tim[TIM_STRB_LO +: 4] == 4'h0)
                                      ? TMO_DEFAULT_TCY * 12'(QPH_PER_TCY)
                                      : {6'h0, tim[TIM_STRB_LO +: 4], 2'h0};
                    end
                    else
                        cnt_ff <= cnt_ff - 6'h01;
                end
                ST_STRB:
                begin
                    if (tim_cnt_done(cnt_ff, tim[TIM_HANDSHAKE_MODE_LO +: 2], ack_seen,
                                     tmo_cnt_ff))
                    begin
                        state_ff <= ST_HOLD;
                        tmo_ff   <= tim[TIM_HANDSHAKE_MODE_LO +: 2] == ACK_TMO && !ack_seen
                                    && tmo_cnt_ff <= 12'h001;
                        cnt_ff   <= {2'h0, tim[TIM_HOLD_LO +: 2], 2'h0}
                                    + (ctl_ff[CTL_DIR_BIT] ? {4'h0, Q_ONE} : 6'h00);
                    end
                    else
                    begin
                        if (cnt_ff != 6'h00)
                            cnt_ff <= cnt_ff - 6'h01;
                        if (tmo_cnt_ff != 12'h000)
                            tmo_cnt_ff <= tmo_cnt_ff - 12'h001;
                    end
                end
                ST_HOLD:
                begin
                    if (cnt_ff <= 6'h01)
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - 6'h01;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    // strobe phase ends on its count; wait mode also needs the handshake, timeout mode ends on handshake or timeout alone
    function automatic logic tim_cnt_done(input logic [5:0] c, input logic [1:0] m,
                                          input logic a, input logic [11:0] t);
        logic base_done;
        base_done = c <= 6'h01;
        case (m)
            ACK_WAIT: tim_cnt_done = base_done && a;
            ACK_TMO:  tim_cnt_done = a || t <= 12'h001;
            default:  tim_cnt_done = base_done;
        endcase
    endfunction
    // ================================================================
    // pin levels: strobe and lane lines are their active flag xnor a polarity bit; select too, but held low unless pin bit set and off bit clear; data_oe has none
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pins_ff <= '0;
        else
        begin
            for (int i = 0; i < 2; i++)
                pins_ff.select[i] <= cfg_ff[i][CFG_PIN_BIT] && !cfg_ff[i][CFG_OFF_BIT]
                    && ((state_ff != ST_IDLE && cs == 1'(i)) ~^ cfg_ff[i][CFG_CSPOL_BIT]);
            if (master && cfg[CFG_SM_BIT])
            begin
                pins_ff.read_strobe  <= !ctl_ff[CTL_DIR_BIT] ~^ cfg[CFG_RDP_BIT];
                pins_ff.write_strobe <= (state_ff == ST_STRB) ~^ cfg[CFG_WRP_BIT];
            end
            else
            begin
                pins_ff.read_strobe  <= (state_ff == ST_STRB && !ctl_ff[CTL_DIR_BIT])
                                        ~^ cfg[CFG_RDP_BIT];
                pins_ff.write_strobe <= (state_ff == ST_STRB && ctl_ff[CTL_DIR_BIT])
                                        ~^ cfg[CFG_WRP_BIT];
            end
            pins_ff.lane0_en <= (state_ff != ST_IDLE) ~^ cfg[CFG_BEP_BIT];
            pins_ff.lane1_en <= (state_ff != ST_IDLE && cfg[CFG_BUS_WIDTH_SEL_LO +: 2] == WIDTH_16)
                                ~^ cfg[CFG_BEP_BIT];
            pins_ff.data_oe  <= state_ff != ST_IDLE && ctl_ff[CTL_DIR_BIT];
        end
    end
    assign pins = pins_ff;
    // width, alternate master wait and region outputs, all registered
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bus_width_sel   <= 2'h0;
            alt_master_wait <= AMW_BASE;
            irq_ff          <= 1'b0;
        end
        else
        begin
            bus_width_sel   <= cfg[CFG_BUS_WIDTH_SEL_LO +: 2];
            alt_master_wait <= {1'b0, tim[TIM_AMW_LO +: 3]} + AMW_BASE;
            irq_ff <= ctl_ff[1:0] == MODE_BUF && ctl_ff[CTL_IRQ_LO +: 2] == IRQ_LAST
                      && last_event;
        end
    end
    assign region_extend = region_ext_ff;
    assign buf_irq       = irq_ff;
    // ================================================================
    // slave buffers; software reads in and writes out via status index
    ppc_slave_buf #(.NBUF(4)) u_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .host_wr   (host_wr && !master),
        .host_rd   (host_rd && !master),
        .host_idx  (host_idx),
        .sw_in_rd  (rd_acc && avs_address == ADDR_STATUS && avs_byteenable[3]),
        .sw_out_wr (wr_acc && avs_address == ADDR_STATUS && avs_byteenable[3]),
        .sw_idx    (avs_writedata[25:24]),
        .clr_ov    (wr_acc && avs_address == ADDR_STATUS && !wdata[ST_INBUF_OVERFLOW]),
        .clr_uf    (wr_acc && avs_address == ADDR_STATUS && !wdata[ST_OUTBUF_UNDERFLOW]),
        .status    (status),
        .last_event(last_event)
    );
    // ================================================================
    // checks
    a_base_reset: assert property (@(posedge sys_clk) !rst_n |=> base_ff[1] == CS2_BASE_RST)
        else $error("second base not at reset value");
    a_ack_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_STRB && tim[TIM_HANDSHAKE_MODE_LO +: 2] == ACK_WAIT && !ack_seen
        |=> state_ff == ST_STRB)
        else $error("strobe ended without handshake");
    a_setup_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_SETUP |=> state_ff inside {ST_SETUP, ST_STRB})
        else $error("setup not followed by strobe");
    a_base_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        base_ff[0][6:0] == 7'h00)
        else $error("base low bits not zero");
    a_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_IDLE && cfg[CFG_OFF_BIT] |=> state_ff == ST_IDLE)
        else $error("disabled select started transfer");
    a_amw_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 alt_master_wait == $past({1'b0, tim[TIM_AMW_LO +: 3]}) + AMW_BASE)
        else $error("alternate wait wrong");
    a_lane_pol: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_ff == ST_IDLE ##1 state_ff == ST_IDLE |=> pins.lane0_en == !$past(cfg[CFG_BEP_BIT]))
        else $error("idle lane enable level wrong");
    a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status[ST_INBUF_OVERFLOW] && !(wr_acc && avs_address == ADDR_STATUS) |=> status[ST_INBUF_OVERFLOW])
        else $error("overflow flag lost");
    a_full_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status[ST_IBF] == &status[11:8])
        else $error("full summary mismatch");
    c_master_xfer: cover property (@(posedge sys_clk) state_ff == ST_HOLD ##1 state_ff == ST_IDLE);
    c_timeout: cover property (@(posedge sys_clk) tmo_ff);
    c_overflow: cover property (@(posedge sys_clk) $rose(status[ST_INBUF_OVERFLOW]));
endmodule

//--- core/ppc_slave_buf.sv
// slave byte buffers with full, empty, overflow and underflow flags
`timescale 1ns/10ps
module ppc_slave_buf
    import ppc_pkg::*;
#(
    parameter int NBUF = 4
)(
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            host_wr,
    input  wire logic            host_rd,
    input  wire logic [1:0]      host_idx,
    input  wire logic            sw_in_rd,
    input  wire logic            sw_out_wr,
    input  wire logic [1:0]      sw_idx,
    input  wire logic            clr_ov,
    input  wire logic            clr_uf,
    output logic [15:0]          status,
    output logic                 last_event
);
    logic [NBUF-1:0] in_full_ff;
    logic [NBUF-1:0] out_empty_ff;
    logic            ov_ff;
    logic            uf_ff;
    // ================================================================
    // per-buffer flags; a pair of bytes clears together
    genvar g;
    generate
        for (g = 0; g < NBUF; g++)
        begin : g_buf
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    in_full_ff[g] <= 1'b0;
                else if (host_wr && host_idx == 2'(g))
                    in_full_ff[g] <= 1'b1;                       // set wins
                else if (sw_in_rd && sw_idx[1] == 1'(g / 2))
                    in_full_ff[g] <= 1'b0;
            end
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    out_empty_ff[g] <= 1'b1;
                else if (sw_out_wr && sw_idx == 2'(g))
                    out_empty_ff[g] <= 1'b0;
                else if (host_rd && host_idx[1] == 1'(g / 2))
                    out_empty_ff[g] <= 1'b1;
            end
        end
    endgenerate
    // sticky error flags; a new event wins over the clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ov_ff <= 1'b0;
            uf_ff <= 1'b0;
        end
        else
        begin
            if (host_wr && in_full_ff[host_idx])
                ov_ff <= 1'b1;
            else if (clr_ov)
                ov_ff <= 1'b0;
            if (host_rd && out_empty_ff[host_idx])
                uf_ff <= 1'b1;
            else if (clr_uf)
                uf_ff <= 1'b0;
        end
    end
    // summary flags are combinational over the per-buffer state
    always_comb
    begin
        status = 16'h0000;
        status[ST_IBF]  = &in_full_ff;
        status[ST_INBUF_OVERFLOW] = ov_ff;
        status[11:8]    = in_full_ff;
        status[ST_OBE]  = &out_empty_ff;
        status[ST_OUTBUF_UNDERFLOW] = uf_ff;
        status[3:0]     = out_empty_ff;
    end
    assign last_event = (host_rd || host_wr) && host_idx == 2'h3;
endmodule

//--- dv/ppc_ext_model.sv
// external peripheral that answers master write strobes with a handshake
`timescale 1ns/10ps
module ppc_ext_model
    import ppc_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire ppc_pkg::ppc_pins_t pins,
    input  wire logic               mute,
    output logic                    ext_handshake_in
);
    logic [2:0] cnt_ff;
    // count cycles of an active-low write strobe; a muted device never answers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || pins.write_strobe)
            cnt_ff <= 3'h0;
        else if (cnt_ff != 3'h7)
            cnt_ff <= cnt_ff + 3'h1;
        ext_handshake_in <= !(cnt_ff >= 3'h2 && !mute); // low means acknowledge
    end
endmodule

//--- dv/tb_top.sv
// self-checking bench for the parallel port block
`timescale 1ns/10ps
module tb_top;
    import ppc_pkg::*;
    logic sys_clk, rst_n, avs_read, avs_write, hs, host_wr, host_rd, mute, buf_irq;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, r;
    logic [3:0]  avs_byteenable, amw;
    logic [1:0]  host_idx, bws;
    logic        avs_waitrequest, region_extend;
    ppc_pins_t   pins;
    logic [63:0] note_q[$];
    logic [63:0] note;
    int          err_count, tests_run, irq_count;
    ppc_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_handshake_in(hs), .host_wr(host_wr),
        .host_rd(host_rd), .host_idx(host_idx), .pins(pins), .bus_width_sel(bws),
        .region_extend(region_extend), .alt_master_wait(amw), .buf_irq(buf_irq));
    ppc_ext_model ext_u (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .mute(mute),
        .ext_handshake_in(hs));
    // ===========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon cycle; reads leave a masked note for the monitor
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [31:0] m, input logic [31:0] e);
        if (!w)
            note_q.push_back({m, e});
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic host(input logic wr, input logic [1:0] i);
        host_wr <= wr;
        host_rd <= !wr;
        host_idx <= i;
        @(posedge sys_clk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ===========================================
    // clock, monitor, watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // read data is taken at the edge where waitrequest is low
    always @(posedge sys_clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0 && note_q.size() > 0)
        begin
            note = note_q.pop_front();
            chk(avs_readdata & note[63:32], note[31:0]);
        end
    end
    // count interrupt pulses; each stands for one cycle only
    always @(posedge sys_clk)
    begin
        if (buf_irq === 1'b1)
            irq_count++;
    end
    initial
    begin
        #100000;
        err_count++;
        print_verdict();
    end
    // ===========================================
    // main sequence
    initial
    begin
        {avs_read, avs_write, host_wr, host_rd, mute} = 5'h0;
        {avs_address, avs_writedata, avs_byteenable, host_idx} = '0;
        err_count = 0;
        tests_run = 0;
        irq_count = 0;
        rst_n = 1'b0;
        void'($urandom(32'h5BB8));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(0, ADDR_CS1_BASE, 0, 4'h3, 32'hFFFFFFFF, 32'h0080);
        bus(0, ADDR_CS2_BASE, 0, 4'h3, 32'hFFFFFFFF, 32'h0880);
        bus(0, ADDR_STATUS, 0, 4'h3, 32'hFFFF, 32'h008F);
        bus(0, 5'h1E, 0, 4'h3, 32'hFFFFFFFF, 32'h0); // unmapped
        chk(32'(pins.lane0_en), 32'h1);
        r = $urandom() | 32'h0080;
        bus(1, ADDR_CS1_BASE, r, 4'h3, 0, 0);
        bus(0, ADDR_CS1_BASE, 0, 4'h3, 32'hFFFF, 32'(r[15:0] & 16'hFF80));
        bus(1, ADDR_CS2_BASE, 0, 4'h3, 0, 0);
        chk(32'(region_extend), 32'h1);
        bus(1, ADDR_CS1_CFG, 32'h3040, 4'h3, 0, 0);
        chk(32'({pins.lane0_en, bws}), 32'h2);
        bus(1, ADDR_CS1_TIM, 32'h7808, 4'h3, 0, 0);
        chk(32'(amw), 32'hA);
        // master write, handshake with timeout of two Tcy, device silent
        mute <= 1'b1;
        bus(1, ADDR_CONTROL, 32'h33, 4'h3, 0, 0);
        repeat (40) @(posedge sys_clk);
        bus(0, ADDR_CONTROL, 0, 4'h3, 32'h300, 32'h200);
        // master write waiting for the handshake, device answers
        mute <= 1'b0;
        bus(1, ADDR_CS1_TIM, 32'h8000, 4'h3, 0, 0);
        bus(1, ADDR_CONTROL, 32'h33, 4'h3, 0, 0);
        repeat (40) @(posedge sys_clk);
        bus(0, ADDR_CONTROL, 0, 4'h3, 32'h300, 32'h000);
        // slave buffers: fill, overflow, pair clear, underflow
        bus(1, ADDR_CONTROL, 0, 4'h3, 0, 0);
        for (int i = 0; i < 4; i++)
            host(1, 2'(i));
        bus(0, ADDR_STATUS, 0, 4'h3, 32'hFFFF, 32'h8F8F);
        host(1, 2'h2);
        bus(0, ADDR_STATUS, 0, 4'hB, 32'hFFFF, 32'hCF8F);
        bus(0, ADDR_STATUS, 0, 4'h3, 32'hFFFF, 32'h4C8F);
        host(0, 2'h1);
        bus(0, ADDR_STATUS, 0, 4'h3, 32'hFFFF, 32'h4CCF);
        // software clears both sticky flags by writing zeros
        bus(1, ADDR_STATUS, 0, 4'h3, 0, 0);
        bus(0, ADDR_STATUS, 0, 4'h3, 32'hFFFF, 32'h0C8F);
        // buffered slave, interrupt on last buffer access
        bus(1, ADDR_CONTROL, 32'h0D, 4'h3, 0, 0);
        host(1, 2'h3);
        @(posedge sys_clk);
        chk(32'(irq_count), 32'h1);
        repeat (3) @(posedge sys_clk);
        print_verdict();
    end
endmodule
